// ---- shared/twsp_pkg.sv ----
// constants shared by both ends of the touch wheel serial port
// assumes a 40 MHz system clock on both ends and a serial clock near 20 kHz
// Notes on behaviour
// - wait settling delay after sleep before burst
// - no settling delay without preceding sleep
// - release data output when shift ends
// - host gives each sensor its own select
// - go line undriven 20ms after power-up, then low
// - go line low 520ms calibrating, then high
// - data out changes on falling clock edge
// - data in sampled on rising clock edge
// - host holds select low whole transfer
// - go line low means host must not clock
// - eight bits, most significant bit first
// - serial clock between 5 kHz and 40 kHz
// - both bytes shift in the same cycles
// - returned byte lags one transfer behind
// - sleep after transfer; select rise wakes, bursts
// - status byte: touch flag, position or flags
package twsp_pkg;
	localparam int CLK_HZ          = 40000000;
	localparam int SETTLE_US       = 500;
	localparam int FLOAT_MS        = 20;
	localparam int CAL_MS          = 520;
	localparam int GAP_US          = 35;
	localparam int SCK_HZ          = 20000;
	localparam int BURST_US        = 100;
	localparam int SETTLE_CYC      = (SETTLE_US * (CLK_HZ / 1000000));
	localparam int FLOAT_CYC       = (FLOAT_MS * (CLK_HZ / 1000));
	localparam int CAL_CYC         = (CAL_MS * (CLK_HZ / 1000));
	localparam int GAP_CYC         = (GAP_US * (CLK_HZ / 1000000));
	localparam int BURST_CYC       = (BURST_US * (CLK_HZ / 1000000));
	localparam int HALF_SCK_CYC    = CLK_HZ / (2 * SCK_HZ);
	localparam int BYTE_BITS       = 8;
	localparam int TOUCH_BIT       = 7;
	localparam int TYPE_BIT        = 6;
	localparam int ERROR_BIT       = 1;
	localparam int PROX_BIT        = 0;
	localparam logic [7:0] RESP_RESET = 8'h00;
endpackage

// ---- shared/twsp_if.sv ----
// serial link between host and touch wheel sensor
// assumes each reader resolves the shared return wires from their enables
`timescale 1ns/10ps
interface twsp_if;
	logic sclk;
	logic sel_n;
	logic host_data;
	logic dev_data_o;
	logic dev_data_oe_n;
	logic host_go_line_o;
	logic host_go_line_oe_n;
	modport device (
		input  sclk,
		input  sel_n,
		input  host_data,
		output dev_data_o,
		output dev_data_oe_n,
		output host_go_line_o,
		output host_go_line_oe_n
	);
	modport host (
		output sclk,
		output sel_n,
		output host_data,
		input  dev_data_o,
		input  dev_data_oe_n,
		input  host_go_line_o,
		input  host_go_line_oe_n
	);
endinterface

// ---- src/twsp_device.sv ----
// sensor end of the serial port: shifter, sleep, burst and power-up sequence
// assumes link pins arrive asynchronously; sensing core supplies status fields
`timescale 1ns/10ps
module twsp_device #(
	parameter int FLOAT_CYC  = twsp_pkg::FLOAT_CYC,
	parameter int CAL_CYC    = twsp_pkg::CAL_CYC,
	parameter int SETTLE_CYC = twsp_pkg::SETTLE_CYC,
	parameter int BURST_CYC  = twsp_pkg::BURST_CYC
) (
	input  wire logic       SYS_CLK,
	input  wire logic       SRST,
	twsp_if.device          LINK,
	input  wire logic       TOUCHED,
	input  wire logic [6:0] POSITION,
	input  wire logic       WHEEL_TYPE,
	input  wire logic       CAL_ERROR,
	input  wire logic       PROX,
	output logic [7:0]      CMD_BYTE,
	output logic            CMD_VALID,
	output logic            BURST_ACTIVE
);
	initial begin
		if (FLOAT_CYC < 1 || CAL_CYC < 1 || SETTLE_CYC < 1 || BURST_CYC < 1)
			$error("twsp_device: counts must be at least one");
	end

	typedef enum {ST_FLOAT, ST_CAL, ST_IDLE, ST_SLEEP, ST_SETTLE, ST_BURST} twsp_dev_type;
	twsp_dev_type state_q;

	logic [2:0] sclk_s_q, sel_s_q;
	logic [1:0] din_s_q;
	logic [31:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] rx_q, tx_q, resp_q;
	logic       oe_n_q, dout_q, slept_q;

	wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
	wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
	wire sel_rise  = sel_s_q[1] & ~sel_s_q[2];
	wire sel_fall  = ~sel_s_q[1] & sel_s_q[2];
	wire in_frame  = ~sel_s_q[1];
	wire last_bit  = sclk_rise && in_frame && bit_q == 3'h7;

	// second and third stages only are read; first stage feeds the second alone
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			sclk_s_q <= 3'h7;
			sel_s_q  <= 3'h7;
			din_s_q  <= 2'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], LINK.sclk};
			sel_s_q  <= {sel_s_q[1:0], LINK.sel_n};
			din_s_q  <= {din_s_q[0], LINK.host_data};
		end
	end

	// status byte built from the sensing core's fields
	function automatic logic [7:0] status_byte(input logic t, input logic [6:0] p,
		input logic w, input logic e, input logic x);
		logic [7:0] r;
		r = 8'h00;
		if (t) begin
			r = {1'b1, p};
		end else begin
			r[twsp_pkg::TYPE_BIT]  = w;
			r[twsp_pkg::ERROR_BIT] = e;
			r[twsp_pkg::PROX_BIT]  = x;
		end
		return r;
	endfunction

	// power-up, sleep and burst sequencing
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_q <= ST_FLOAT;
			cnt_q   <= 32'h0;
			slept_q <= 1'b0;
			resp_q  <= twsp_pkg::RESP_RESET;
		end else begin
			case (state_q)
				ST_FLOAT: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(FLOAT_CYC - 1)) begin
						state_q <= ST_CAL;
						cnt_q   <= 32'h0;
					end
				end
				ST_CAL: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(CAL_CYC - 1)) begin
						state_q <= ST_IDLE;
						cnt_q   <= 32'h0;
						resp_q  <= status_byte(TOUCHED, POSITION, WHEEL_TYPE, CAL_ERROR, PROX);
					end
				end
				ST_IDLE: begin
					if (last_bit) begin
						state_q <= ST_SLEEP;
						slept_q <= 1'b1;
					end else if (sel_rise) begin
						state_q <= slept_q ? ST_SETTLE : ST_BURST;
						cnt_q   <= 32'h0;
					end
				end
				ST_SLEEP: begin
					if (sel_rise) begin
						state_q <= ST_SETTLE;
						cnt_q   <= 32'h0;
					end
				end
				ST_SETTLE: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(SETTLE_CYC - 1)) begin
						state_q <= ST_BURST;
						cnt_q   <= 32'h0;
						slept_q <= 1'b0;
					end
				end
				ST_BURST: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(BURST_CYC - 1)) begin
						state_q <= ST_IDLE;
						cnt_q   <= 32'h0;
						// result of this burst goes out in the next frame
						resp_q  <= status_byte(TOUCHED, POSITION, WHEEL_TYPE, CAL_ERROR, PROX);
					end
				end
				default: state_q <= ST_FLOAT;
			endcase
		end
	end

	// shifter; frames while busy are ignored, the host should be waiting anyway
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			bit_q     <= 3'h0;
			rx_q      <= 8'h00;
			tx_q      <= 8'h00;
			dout_q    <= 1'b1;
			oe_n_q    <= 1'b1;
			CMD_BYTE  <= 8'h00;
			CMD_VALID <= 1'b0;
		end else begin
			CMD_VALID <= 1'b0;
			if (sel_rise || state_q != ST_IDLE) begin
				bit_q  <= 3'h0;
				oe_n_q <= 1'b1;
			end else if (sel_fall) begin
				tx_q   <= {resp_q[6:0], 1'b0};
				dout_q <= resp_q[7];
				oe_n_q <= 1'b0;
				bit_q  <= 3'h0;
			end else if (in_frame && sclk_fall && bit_q != 3'h0) begin
				dout_q <= tx_q[7];
				tx_q   <= {tx_q[6:0], 1'b0};
			end else if (in_frame && sclk_rise) begin
				rx_q  <= {rx_q[6:0], din_s_q[1]};
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					// both bytes complete together
					CMD_BYTE  <= {rx_q[6:0], din_s_q[1]};
					CMD_VALID <= 1'b1;
					oe_n_q    <= 1'b1;
				end
			end
		end
	end

	assign LINK.dev_data_o        = dout_q;
	assign LINK.dev_data_oe_n     = oe_n_q;
	assign LINK.host_go_line_o    = (state_q == ST_IDLE) && !slept_q;
	assign LINK.host_go_line_oe_n = (state_q == ST_FLOAT);
	assign BURST_ACTIVE           = (state_q == ST_BURST);
endmodule

// ---- src/twsp_host.sv ----
// host end: one full duplex byte per frame, clock made by a divider
// assumes the sensor answers on the shared return wire and go line
`timescale 1ns/10ps
module twsp_host #(
	parameter int HALF_CYC = twsp_pkg::HALF_SCK_CYC,
	parameter int GAP_CYC  = twsp_pkg::GAP_CYC
) (
	input  wire logic       SYS_CLK,
	input  wire logic       SRST,
	twsp_if.host            LINK,
	input  wire logic [7:0] TX_BYTE,
	input  wire logic       TX_VALID,
	output logic            TX_READY,
	output logic [7:0]      RX_BYTE,
	output logic            RX_VALID
);
	initial begin
		// 40 kHz ceiling needs 500 cycles per half period at 40 MHz
		if (HALF_CYC < 1 || GAP_CYC < 1)
			$error("twsp_host: counts must be at least one");
	end

	typedef enum {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP} twsp_host_type;
	twsp_host_type state_q;

	logic [1:0]  go_s_q, din_s_q;
	logic [31:0] cnt_q;
	logic [2:0]  bit_q;
	logic [7:0]  tx_q, rx_q;
	logic        sclk_q, sel_n_q, dout_q;

	wire go = go_s_q[1];

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			go_s_q  <= 2'h0;
			din_s_q <= 2'h0;
		end else begin
			// an undriven go line counts as low
			go_s_q  <= {go_s_q[0], LINK.host_go_line_o & ~LINK.host_go_line_oe_n};
			// a released return wire reads low, so an early release shows as a wrong bit
			din_s_q <= {din_s_q[0], LINK.dev_data_o & ~LINK.dev_data_oe_n};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_q  <= HS_IDLE;
			cnt_q    <= 32'h0;
			bit_q    <= 3'h0;
			tx_q     <= 8'h00;
			rx_q     <= 8'h00;
			sclk_q   <= 1'b1;
			sel_n_q  <= 1'b1;
			dout_q   <= 1'b0;
			RX_BYTE  <= 8'h00;
			RX_VALID <= 1'b0;
		end else begin
			RX_VALID <= 1'b0;
			case (state_q)
				HS_IDLE: begin
					sclk_q <= 1'b1;
					if (TX_VALID && go) begin
						sel_n_q <= 1'b0;
						tx_q    <= {TX_BYTE[6:0], 1'b0};
						dout_q  <= TX_BYTE[7];
						bit_q   <= 3'h0;
						cnt_q   <= 32'h0;
						state_q <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(HALF_CYC - 1)) begin
						cnt_q   <= 32'h0;
						sclk_q  <= 1'b0;
						state_q <= HS_LOW;
						if (bit_q != 3'h0) begin
							dout_q <= tx_q[7];
							tx_q   <= {tx_q[6:0], 1'b0};
						end
					end
				end
				HS_LOW: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(HALF_CYC - 1)) begin
						cnt_q  <= 32'h0;
						sclk_q <= 1'b1;
						rx_q   <= {rx_q[6:0], din_s_q[1]};
						bit_q  <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							RX_BYTE  <= {rx_q[6:0], din_s_q[1]};
							RX_VALID <= 1'b1;
							state_q  <= HS_GAP;
						end else begin
							state_q <= HS_HIGH;
						end
					end
				end
				HS_GAP: begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(GAP_CYC)) begin
						sel_n_q <= 1'b1;
						state_q <= HS_IDLE;
					end
				end
				default: state_q <= HS_IDLE;
			endcase
		end
	end

	// one select per sensor; a second sensor needs a second instance
	assign LINK.sel_n     = sel_n_q;
	assign LINK.sclk      = sclk_q;
	assign LINK.host_data = dout_q;
	assign TX_READY       = (state_q == HS_IDLE) && go;
endmodule

// ---- test/twsp_link_sva.sv ----
// link checker: both ends of the serial link seen from the wires
// assumes every link signal is sampled in the SYS_CLK domain
`timescale 1ns/10ps
module twsp_link_sva #(
	parameter int SETTLE_CYC = 20,
	parameter int BURST_CYC  = 20,
	parameter int GAP_CYC    = 30
) (
	input logic SYS_CLK,
	input logic SRST,
	input logic sclk,
	input logic sel_n,
	input logic host_data,
	input logic dev_data_o,
	input logic dev_data_oe_n,
	input logic host_go_line_o,
	input logic host_go_line_oe_n
);
	localparam int CAL_MAX = 300;
	logic        sclk_q;
	logic        sel_q;
	logic [3:0]  rise_q;
	logic [15:0] since_q;
	logic [15:0] wake_q;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	always_ff @(posedge SYS_CLK) begin
		sclk_q <= sclk;
		sel_q  <= sel_n;
	end
	always_ff @(posedge SYS_CLK) begin
		if (SRST || sel_n) begin
			rise_q <= 4'h0;
		end else if (sclk && !sclk_q) begin
			rise_q <= rise_q + 4'h1;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (SRST || (sclk && !sclk_q)) begin
			since_q <= 16'h0;
		end else if (since_q != 16'hFFFF) begin
			since_q <= since_q + 16'h1;
		end
	end
	// zero until the first frame ends, so the power-up rise is not judged here
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			wake_q <= 16'h0;
		end else if (sel_n && !sel_q) begin
			wake_q <= 16'h1;
		end else if (wake_q != 16'h0 && wake_q != 16'hFFFF) begin
			wake_q <= wake_q + 16'h1;
		end
	end
	sequence busy_s;
		(host_go_line_oe_n || !host_go_line_o) [*4];
	endsequence
	sequence frame_end_s;
		$rose(sel_n);
	endsequence
	release_out_a: assert property (sel_n [*5] |-> dev_data_oe_n)
		else $error("data output still driven between frames");
	idle_clock_a: assert property (sel_n |-> sclk)
		else $error("serial clock low outside a frame");
	host_shift_a: assert property ($changed(host_data) && !sel_n && $past(!sel_n) |-> !sclk)
		else $error("host data changed while clock high");
	dev_shift_a: assert property ($changed(dev_data_o) && !dev_data_oe_n
		&& $past(!dev_data_oe_n) |-> !sclk)
		else $error("device data changed while clock high");
	bit_count_a: assert property (frame_end_s |-> rise_q == 4'h8)
		else $error("frame did not hold eight clock rises");
	sel_gap_a: assert property (frame_end_s |-> since_q >= GAP_CYC - 1 && !host_go_line_o)
		else $error("select rose too early or go line still high");
	busy_hold_a: assert property (busy_s |=> !$fell(sel_n))
		else $error("frame started while go line low");
	power_float_a: assert property ($fell(SRST) |-> host_go_line_oe_n [*8])
		else $error("go line driven too soon after power-up");
	cal_low_a: assert property ($fell(host_go_line_oe_n) |-> !host_go_line_o [*8]
		##[1:CAL_MAX] host_go_line_o)
		else $error("go line not low then high around calibration");
	settle_delay_a: assert property ($rose(host_go_line_o) && wake_q != 16'h0
		|-> wake_q >= SETTLE_CYC + BURST_CYC)
		else $error("burst ended before settling delay");
endmodule

// ---- test/touch_wheel_spi_slave_port_test.sv ----
// bench: host end and sensor end joined on one link
// assumes shortened power-up, settle and burst counts
`timescale 1ns/10ps
module touch_wheel_spi_slave_port_test;
	localparam int SETTLE = 20;
	localparam int BURST  = 20;
	localparam int GAP    = 30;
	localparam logic [31:0] CMDS = 32'hA55A807F;
	localparam logic [43:0] TAB  = {11'h550, 11'h002, 11'h7F8, 11'h2AF};
	logic        sys_clk;
	logic        srst;
	logic [10:0] st;
	logic [7:0]  tx_byte;
	logic        tx_valid;
	logic        tx_ready;
	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic [7:0]  cmd_byte;
	logic        cmd_valid;
	logic        burst_active;
	int          bad_count;
	int          n_tests;
	twsp_if link ();
	twsp_device #(.FLOAT_CYC(50), .CAL_CYC(100), .SETTLE_CYC(SETTLE), .BURST_CYC(BURST))
	i_twsp_device (.SYS_CLK(sys_clk), .SRST(srst), .LINK(link), .TOUCHED(st[10]),
		.POSITION(st[9:3]), .WHEEL_TYPE(st[2]), .CAL_ERROR(st[1]), .PROX(st[0]),
		.CMD_BYTE(cmd_byte), .CMD_VALID(cmd_valid), .BURST_ACTIVE(burst_active));
	twsp_host #(.HALF_CYC(20), .GAP_CYC(GAP)) i_twsp_host (.SYS_CLK(sys_clk), .SRST(srst),
		.LINK(link), .TX_BYTE(tx_byte), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.RX_BYTE(rx_byte), .RX_VALID(rx_valid));
	twsp_link_sva #(.SETTLE_CYC(SETTLE), .BURST_CYC(BURST), .GAP_CYC(GAP)) i_twsp_link_sva (
		.SYS_CLK(sys_clk), .SRST(srst), .sclk(link.sclk), .sel_n(link.sel_n),
		.host_data(link.host_data), .dev_data_o(link.dev_data_o),
		.dev_data_oe_n(link.dev_data_oe_n), .host_go_line_o(link.host_go_line_o),
		.host_go_line_oe_n(link.host_go_line_oe_n));
	function automatic logic [7:0] exp_of(input logic [10:0] s);
		return s[10] ? {1'b1, s[9:3]} : {1'b0, s[2], 4'h0, s[1:0]};
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	// bounded wait on a flag, looked at 1 ns after each edge: 0 ready, 1 reply, 2 command, 3 burst
	task automatic wait_hi(input int w);
		int n;
		n = 0;
		while ((w == 0 ? tx_ready : w == 1 ? rx_valid :
			w == 2 ? cmd_valid : burst_active) !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > 3000) begin
				cmp(8'h01, 8'h00);
				complete_run();
			end
		end
	endtask
	// nxt is applied mid-frame so the following burst captures it
	task automatic xfer(input logic [7:0] tx, input logic [7:0] exp, input logic [10:0] nxt);
		int n;
		wait_hi(0);
		tx_byte = tx;
		tx_valid = 1'b1;
		@(posedge sys_clk);
		#1 tx_valid = 1'b0;
		wait_hi(1);
		cmp(exp, rx_byte);
		st = nxt;
		wait_hi(2);
		cmp(tx, cmd_byte);
		repeat (GAP + 16) @(posedge sys_clk);
		#1;
		cmp(8'h01, {7'h0, link.dev_data_oe_n});
		// the select rise must start a burst of exactly the set length
		wait_hi(3);
		n = 0;
		while (burst_active === 1'b1 && n < 3000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		cmp(8'(BURST), 8'(n));
	endtask
	task automatic test_power();
		cmp(8'h01, {7'h0, link.host_go_line_oe_n});
		wait_hi(0);
		cmp(8'h01, {7'h0, link.host_go_line_o});
		$display("power-up test done");
	endtask
	task automatic test_frames();
		for (int i = 0; i < 4; i++) begin
			xfer(CMDS[31-8*i -: 8], exp_of(st), TAB[43-11*i -: 11]);
		end
		xfer(8'h00, exp_of(st), st);
		$display("frame test done");
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		srst = 1'b1;
		st = 11'h005;
		tx_byte = 8'h00;
		tx_valid = 1'b0;
		bad_count = 0;
		n_tests = 0;
		repeat (20) @(posedge sys_clk);
		#1 srst = 1'b0;
		test_power();
		test_frames();
		complete_run();
	end
endmodule
